// ===== core/rtcpsc_pkg.sv
// rtcpsc_pkg: constants and carrier types of the rtc time-base prescaler
// assumes a single 10 MHz system clock; the 32.768 kHz tick arrives as a pin level
package rtcpsc_pkg;
    localparam int          CLK_HZ          = 10000000;
    localparam int          LOW_STAGES      = 9;
    localparam int          HIGH_STAGES     = 6;
    localparam int          PSC_W           = LOW_STAGES + HIGH_STAGES;
    localparam logic [14:0] PSC_RESET       = 15'h0000;
    localparam logic [5:0]  HIGH_RESET      = 6'h00;
    localparam int          TEST_EDGES_FULL = 64;
    localparam int          TEST_EDGES_HALF = 32;
    localparam int          SYNC_STAGES     = 2;

    typedef struct packed {
        logic test_enable;
        logic freeze;
    } rtcpsc_ctrl_s;

    typedef struct packed {
        logic drive_o;
        logic oe;
    } rtcpsc_pin_s;
endpackage

// ===== core/rtcpsc_sync.sv
// rtcpsc_sync: two flip-flop level synchroniser with rising edge detect
// assumes the input is asynchronous to clock_i; edge looks only at stage two
`timescale 1ns/1ps
module rtcpsc_sync
    import rtcpsc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
endmodule

// ===== core/rtcpsc_top.sv
// rtcpsc_top: rtc time-base prescaler with freeze and external clock test mode
// assumes control bits come from logic on clock_i; pins pass two flip-flops
// Summary of operation
// - test mode is entered when external_clock_test_enable is written one.
// - in test mode clock_output_pin is released and used as input.
// - in test mode pin edges replace the internal 64 Hz clock.
// - in test mode every 64 pin rising edges give one second.
// - freeze forces prescaler high stages to zero until cleared.
// - after freeze release in test mode, first second after 32 edges.
// - test mode entry is unsynchronised; prescaler state at entry undefined.
// - while frozen the upper stages stay in reset, no 1 Hz ticks.
// - while frozen time counters load values and never increment.
// - freeze leaves clock output alone, only 32 Hz to 1 Hz affected.
// - low stages run while frozen outside test mode; first tick 0.484375 s to 0.5 s later.
// - a second is counted on each 0 to 1 transition of the top stage.
// - the first stage is clocked from the 32.768 kHz oscillator.
`timescale 1ns/1ps
module rtcpsc_top
    import rtcpsc_pkg::*;
#(
    parameter int TIME_W = 17
)(
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    input  wire rtcpsc_ctrl_s      ctrl_i,
    input  wire logic              osc_32k_i,
    input  wire logic              clock_output_pin_i,
    input  wire logic              time_load_i,
    input  wire logic [TIME_W-1:0] time_load_value_i,
    output logic                   clock_output_pin_o,
    output logic                   clock_output_pin_oe_o,
    output logic                   second_tick_o,
    output logic [TIME_W-1:0]      time_count_o,
    output logic [PSC_W-1:0]       prescaler_o
);
    logic                   osc_rise;
    logic                   osc_level;
    logic                   pin_rise;
    logic [LOW_STAGES-1:0]  prescaler_low_stages_reg;
    logic [HIGH_STAGES-1:0] prescaler_high_stages_reg;
    logic [HIGH_STAGES-1:0] high_next;
    logic [TIME_W-1:0]      time_reg;
    logic                   tick_reg;
    logic                   pin_o_reg;
    logic                   pin_oe_reg;

    rtcpsc_sync u_osc_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .async_i (osc_32k_i),
        .level_o (osc_level),
        .rise_o  (osc_rise)
    );

    rtcpsc_sync u_pin_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .async_i (clock_output_pin_i),
        .level_o (),
        .rise_o  (pin_rise)
    );

    // low stages: full count from oscillator; test feed enters at the 64 Hz stage
    wire logic low_step   = ~ctrl_i.test_enable & osc_rise;
    wire logic low_carry  = low_step & (&prescaler_low_stages_reg);
    // test mode: pin edge stands in for the 64 Hz carry, unsynchronised to it
    wire logic high_step  = ctrl_i.test_enable ? pin_rise : low_carry;
    wire logic [HIGH_STAGES-1:0] high_inc = prescaler_high_stages_reg + 6'h01;
    // top stage 0->1 is the one-second event; 64 steps per second
    wire logic top_rise   = high_step & ~ctrl_i.freeze & ~prescaler_high_stages_reg[HIGH_STAGES-1]
                            & high_inc[HIGH_STAGES-1];

    // freeze holds upper stages at zero; after release top rises after 32 steps
    assign high_next = ctrl_i.freeze ? HIGH_RESET :
                       (high_step ? high_inc : prescaler_high_stages_reg);

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prescaler_low_stages_reg <= PSC_RESET[LOW_STAGES-1:0];
        end else if (low_step) begin
            // lower stages never see freeze, so restart lands within one 64 Hz period
            prescaler_low_stages_reg <= prescaler_low_stages_reg + 9'h001;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prescaler_high_stages_reg <= HIGH_RESET;
        end else begin
            prescaler_high_stages_reg <= high_next;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            time_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= top_rise;
            // load wins; frozen counters take new values and never advance
            if (time_load_i) begin
                time_reg <= time_load_value_i;
            end else if (top_rise) begin
                time_reg <= time_reg + 1'b1;
            end
        end
    end

    // clock output follows the oscillator, untouched by freeze; released in test mode
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_o_reg  <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            pin_o_reg  <= osc_level;
            pin_oe_reg <= ~ctrl_i.test_enable;
        end
    end

    assign clock_output_pin_o    = pin_o_reg;
    assign clock_output_pin_oe_o = pin_oe_reg;
    assign second_tick_o   = tick_reg;
    assign time_count_o    = time_reg;
    // prescaler_o is a register concatenation, high stages in upper bits
    assign prescaler_o     = {prescaler_high_stages_reg, prescaler_low_stages_reg};

    // helper: counts high-stage steps since freeze release, saturating at 127, for the 32-edge check
    logic [6:0] steps_reg;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            steps_reg <= 7'h00;
        end else if (ctrl_i.freeze) begin
            steps_reg <= 7'h00;
        end else if (high_step && steps_reg != 7'h7f) begin
            steps_reg <= steps_reg + 7'h01;
        end
    end

    sequence frozen_s;
        ctrl_i.freeze;
    endsequence

    freeze_zero_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        frozen_s |=> prescaler_high_stages_reg == HIGH_RESET)
        else $error("high stages not zero while frozen");
    freeze_no_tick_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        frozen_s |=> !second_tick_o)
        else $error("tick while frozen");
    test_release_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ctrl_i.test_enable |=> !clock_output_pin_oe_o)
        else $error("pin driven in test mode");
    normal_drive_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !ctrl_i.test_enable |=> clock_output_pin_oe_o)
        else $error("pin not driven in normal mode");
    first_32_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        top_rise && ctrl_i.test_enable |-> steps_reg == 7'd31 || steps_reg > 7'd32)
        else $error("first second not at 32 edges");
    tick_adv_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        top_rise && !time_load_i |=> time_count_o == $past(time_count_o) + 1'b1)
        else $error("time not advanced on tick");
    load_take_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        time_load_i |=> time_count_o == $past(time_load_value_i))
        else $error("load value not taken");
    test_feed_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ctrl_i.test_enable && !ctrl_i.freeze && pin_rise |=>
        prescaler_high_stages_reg == $past(high_inc))
        else $error("pin edge did not step prescaler");
    low_run_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        frozen_s ##0 low_step |=> prescaler_low_stages_reg != $past(prescaler_low_stages_reg))
        else $error("low stages stopped by freeze");

    // pin edge that the test feed must turn into one high step
    sequence test_edge_s;
        ctrl_i.test_enable && !ctrl_i.freeze && pin_rise;
    endsequence

    // high stages about to cross from 31 to 32, the top stage rising
    sequence top_cross_s;
        high_step && !ctrl_i.freeze && prescaler_high_stages_reg == 6'h1f;
    endsequence

    // tick must be exactly one cycle wide, software counts them
    tick_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        top_cross_s |=> second_tick_o ##1 !second_tick_o)
        else $error("second tick not a single pulse");

    // written out: a named sequence cannot be negated as a boolean
    tick_only_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !(high_step && !ctrl_i.freeze && prescaler_high_stages_reg == 6'h1f) |=> !second_tick_o)
        else $error("tick without top stage rising");

    freeze_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        frozen_s ##0 !time_load_i |=> $stable(time_count_o))
        else $error("time moved while frozen");

    freeze_out_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        frozen_s |=> prescaler_o[PSC_W-1:LOW_STAGES] == HIGH_RESET)
        else $error("prescaler output high stages not zero while frozen");

    test_low_idle_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ctrl_i.test_enable |=> $stable(prescaler_low_stages_reg))
        else $error("low stages ran in test mode");

    // a stale oscillator edge must not leak into the test feed
    test_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ctrl_i.test_enable && !ctrl_i.freeze && !pin_rise |=> $stable(prescaler_high_stages_reg))
        else $error("high stages moved without pin edge");

    osc_feed_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !ctrl_i.test_enable && osc_rise |=>
        prescaler_low_stages_reg == $past(prescaler_low_stages_reg) + 9'h001)
        else $error("oscillator edge did not step low stages");

    test_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        test_edge_s ##0 prescaler_high_stages_reg == 6'h3f |=> prescaler_high_stages_reg == HIGH_RESET)
        else $error("high stages did not wrap after 64 edges");

    // freeze may only touch the slow stages, never the pin drive
    clock_free_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        frozen_s |=> clock_output_pin_o == $past(osc_level))
        else $error("clock output disturbed by freeze");
endmodule

// ===== tb/rtcpsc_tester.sv
// rtcpsc_tester: board tester that drives the test clock onto the pin
// assumes a 10 MHz clock_i; pin stays low between bursts, no free-running clock
`timescale 1ns/1ps
module rtcpsc_tester (
    input  wire logic       clock_i,
    input  wire logic       start_i,
    input  wire logic [7:0] count_i,
    output logic            pin_o,
    output logic            busy_o
);
    logic [7:0] left_reg = 8'h00;
    logic [2:0] phase_reg = 3'h0;
    // 400 ns high, 400 ns low: above the minimum width, inside the maximum period
    always @(posedge clock_i) begin
        if (start_i) begin
            left_reg  <= count_i;
            phase_reg <= 3'h0;
        end else if (left_reg != 8'h00) begin
            phase_reg <= phase_reg + 3'h1;
            if (phase_reg == 3'h7) left_reg <= left_reg - 8'h01;
        end
    end
    assign busy_o = (left_reg != 8'h00);
    assign pin_o  = busy_o && !phase_reg[2];
endmodule

// ===== tb/rtcpsc_top_tb.sv
// rtcpsc_top_tb: self-checking bench for the time-base prescaler
// assumes rtcpsc_tester beside it; oscillator is sped up, one second is never waited out
`timescale 1ns/1ps
module rtcpsc_top_tb;
    import rtcpsc_pkg::*;
    logic clock_i = 0, rst_b_i = 0, osc = 0, load = 0, start = 0, tpin, busy, pin_o, oe, tick, pin_w, prev = 0;
    rtcpsc_ctrl_s ctrl = 2'h0;
    logic [16:0] lval = 17'h0, tcount;
    logic [14:0] psc, p1;
    logic [7:0] npul = 8'h0;
    logic [2:0] oc = 3'h0;
    logic [31:0] lf = 32'h4e4b, ticks = 0, tog = 0, t1, exp_t;
    int n_fail = 0, total_checks = 0;
    assign pin_w = oe ? pin_o : tpin;
    rtcpsc_top u_rtcpsc_top (.clock_i, .rst_b_i, .ctrl_i(ctrl), .osc_32k_i(osc), .clock_output_pin_i(pin_w),
        .time_load_i(load), .time_load_value_i(lval), .clock_output_pin_o(pin_o), .clock_output_pin_oe_o(oe),
        .second_tick_o(tick), .time_count_o(tcount), .prescaler_o(psc));
    rtcpsc_tester u_rtcpsc_tester (.clock_i, .start_i(start), .count_i(npul), .pin_o(tpin), .busy_o(busy));
    initial forever #50 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        oc <= oc + 3'h1;
        if (oc == 3'h7) osc <= ~osc;
        prev <= pin_o;
        if (pin_o !== prev) tog <= tog + 1;
        if (tick === 1'b1) ticks <= ticks + 1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic pulses(input int n);
        int k;
        @(posedge clock_i);
        npul <= n[7:0];
        start <= 1'b1;
        @(posedge clock_i);
        start <= 1'b0;
        #1;
        for (k = 0; k < 3000 && busy === 1'b1; k++) step(1);
        step(8); // sync and edge latency of the pin
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        n_fail++;
        test_done;
    end
    initial begin
        step(20);
        @(posedge clock_i);
        rst_b_i <= 1'b1;
        step(3);
        chk("oe", 1, oe);
        @(posedge clock_i);
        ctrl <= 2'h1;
        step(4);
        p1 = psc;
        t1 = tog;
        step(64);
        chk("low", 4, {23'h0, psc[8:0] - p1[8:0]});
        chk("high", 0, psc[14:9]);
        chk("clock_out", 8, tog - t1);
        $display("done: normal freeze");
        @(posedge clock_i);
        ctrl <= 2'h2;
        step(2);
        @(posedge clock_i);
        ctrl <= 2'h3;
        step(3);
        chk("oe", 0, oe);
        lf = lfsr(lf);
        exp_t = lf[16:0];
        @(posedge clock_i);
        lval <= lf[16:0];
        load <= 1'b1;
        @(posedge clock_i);
        load <= 1'b0;
        step(2);
        chk("time", exp_t, tcount);
        pulses(40);
        chk("time", exp_t, tcount);
        chk("high", 0, psc[14:9]);
        @(posedge clock_i);
        ctrl <= 2'h2;
        pulses(31);
        chk("time", exp_t, tcount);
        pulses(1);
        exp_t++;
        chk("time", exp_t, tcount);
        for (int i = 0; i < 2; i++) begin
            pulses(63);
            chk("time", exp_t, tcount);
            pulses(1);
            exp_t++;
            chk("time", exp_t, tcount);
        end
        chk("high", 6'h20, psc[14:9]);
        chk("ticks", 3, ticks);
        $display("done: test mode");
        @(posedge clock_i);
        ctrl <= 2'h0;
        step(3);
        chk("oe", 1, oe);
        p1 = psc;
        step(64);
        chk("low", 4, {23'h0, psc[8:0] - p1[8:0]});
        chk("high", 6'h20, psc[14:9]);
        $display("done: test exit");
        test_done;
    end
endmodule
